/* hdl/mtc_pkg.sv */
// constants, field layouts and carrier types for the translation control block
// assumes a 32-bit apb register bus and one core clock
package mtc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_USER_ROOT = 8'h04;
  localparam logic [7:0] OFF_SUPV_ROOT = 8'h08;
  localparam logic [7:0] OFF_DWIN0     = 8'h0C;
  localparam logic [7:0] OFF_DWIN1     = 8'h10;
  localparam logic [7:0] OFF_IWIN0     = 8'h14;
  localparam logic [7:0] OFF_IWIN1     = 8'h18;
  localparam logic [7:0] OFF_FLUSH     = 8'h1C;
  localparam logic [7:0] OFF_FILL      = 8'h20;
  localparam logic [7:0] OFF_STATUS    = 8'h24;
  // translation control fields
  localparam int CTL_ENABLE_BIT = 15;
  localparam int CTL_PAGE_BIT   = 14;
  localparam logic [15:0] CTL_WRITE_MASK = 16'hC000;
  // transparent window fields
  localparam logic [31:0] WIN_WRITE_MASK = 32'hFFFFE364;
  localparam int WIN_ENABLE_BIT = 15;
  localparam int WIN_PRIV_HI    = 14;
  localparam int WIN_PRIV_LO    = 13;
  localparam int WIN_UHI_BIT    = 9;
  localparam int WIN_ULO_BIT    = 8;
  localparam int WIN_CM_HI      = 6;
  localparam int WIN_CM_LO      = 5;
  localparam int WIN_WP_BIT     = 2;
  // cache modes
  localparam logic [1:0] CM_WRITE_THROUGH = 2'h0;
  localparam logic [1:0] CM_COPYBACK      = 2'h1;
  localparam logic [1:0] CM_SERIAL        = 2'h2;
  localparam logic [1:0] CM_NONCACHE      = 2'h3;
  // translation cache geometry
  localparam int CACHE_ENTRIES = 64;
  localparam int CACHE_WAYS    = 4;
  localparam int CACHE_SETS    = CACHE_ENTRIES / CACHE_WAYS;
  localparam int SET_BITS      = 4;

  typedef struct packed {
    logic        valid;
    logic        supervisor;
    logic        write;
    logic        instruction;
    logic [31:0] address;
  } mtc_req_t;

  typedef struct packed {
    logic        hit;
    logic        miss;
    logic        abort;
    logic        transparent;
    logic [31:0] address;
    logic [1:0]  cache_mode;
    logic        user_attribute_pin_high;
    logic        user_attribute_pin_low;
  } mtc_rsp_t;

  typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_WAIT_FILL} mtc_state_t;
endpackage : mtc_pkg

/* hdl/mtc_top.sv */
// translation control: translation caches, root pointers, control and windows
// assumes apb from a supervisor-aware bridge, requests from the integer unit,
// and table walk done outside: a miss raises search_req_out and software or a
// walker answers through the fill register
//
// Functional notes
// - lookup is combinational, same cycle as cache indexing, no added delay
// - instruction and data units each own a 64 entry four way cache
// - a miss raises a table search request to obtain the mapping
// - external bus request passes only when the cache controller asks
// - translation disable input turns off paged translation at once
// - registers answer only supervisor accesses; user access gets pslverr
// - two 32-bit root pointers, supervisor and user, long word access
// - control is 16 bits, unimplemented bits read zero, written as zero
// - control writes and reset never flush the translation caches
// - control bit 15 enables paged translation, cleared by reset
// - with translation off the physical address equals the logical address
// - flush works whether translation is enabled or not
// - off and no window match: write-through, no protect, attribute pins low
// - control bit 14 selects 4K or 8K pages, untouched by reset
// - windows work regardless of enable bit and disable input
// - window bits 12-10, 7, 4, 3, 1, 0 read as zero
// - window base compares address bits 31-24, match bypasses tables
// - mask bits exclude base bits from the compare
// - window bit 15 enables its match
// - privilege field: 00 user, 01 supervisor, 1x either
// - user attribute bits go to pins on an external bus transfer
// - window cache mode field selects one of four cache modes
// - write protect aborts writes to the window block
//
// operation overview
// - requests arrive as levels; rsp_out follows req_in in the same cycle
// - priority of a lookup answer:
//   1. an enabled transparent window of the request's side that matches
//   2. paging off (enable bit clear or disable input high): pass through
//   3. a resident entry in the unit's translation cache
//   4. otherwise a miss, which starts a table search
// - a window hit keeps the logical address and takes the window's
//   cache mode, write protect and user attribute bits
// - paging off with no window gives write-through, no protect, pins low
// - attribute pins only show a value while the cache controller asks
//   for an external bus cycle
// - bus_start_out needs a bus request, an answer and no abort
//
// table search
// - the first miss in idle captures the request in search_q
// - search_req_out rises at the next edge and stays high until software
//   writes the fill word or flushes
// - the fill word holds the frame in bits 31-12, user attributes in 9-8,
//   cache mode in 6-5 and write protect in bit 2
// - the entry goes to the captured unit and set, way from a round robin
//   pointer kept per set
// - further misses while a search is pending are not queued; the
//   requester repeats the access after the fill
//
// translation cache
// - two units, instruction and data, sixteen sets of four ways each
// - the tag holds the privilege and the address bits above the set index
// - 4 Kbyte pages index with address bits 15-12, 8 Kbyte with 16-13
// - with 8 Kbyte pages address bit 12 passes through from the request
// - entries carry no reset: valid bits stay unknown until the first
//   flush, so software must flush before it enables paging
// - flush clears every entry of both units, in any enable state
//
// register bus
// - zero wait states: every transfer is a setup and an access cycle
// - read data and the error flag are captured in the setup cycle
// - user accesses and unmapped offsets get pslverr and read zero
// - writes land at the access edge, only for supervisor accesses
// - control keeps its page size bit across reset; software sets it
// - window writes drop the bits that always read zero
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mtc_top (
  // clock and reset
  input  wire  logic                clock_in,
  input  wire  logic                reset_n_in,
  // apb slave
  input  wire  logic                psel_in,
  input  wire  logic                penable_in,
  input  wire  logic                pwrite_in,
  input  wire  logic [7:0]          paddr_in,
  input  wire  logic [31:0]         pwdata_in,
  input  wire  logic                pprot_priv_in,
  output logic                      pready_out,
  output logic [31:0]               prdata_out,
  output logic                      pslverr_out,
  // integer unit request and answer
  input  wire  mtc_pkg::mtc_req_t   req_in,
  output mtc_pkg::mtc_rsp_t         rsp_out,
  // cache controller bus request
  input  wire  logic                bus_request_in,
  output logic                      bus_start_out,
  // emulator disable
  input  wire  logic                translation_disable_in,
  // table search
  output logic                      search_req_out,
  output logic [31:0]               search_addr_out,
  output logic [31:0]               search_root_out,
  output logic                      search_inst_out
);
  localparam int SB = mtc_pkg::SET_BITS;
  localparam int NW = mtc_pkg::CACHE_WAYS;
  localparam int NS = mtc_pkg::CACHE_SETS;

  // control register split into its two live bits
  logic        enable_q;
  logic        page_q;
  logic [15:0] control_q;
  logic [31:0] user_table_root_q;
  logic [31:0] supervisor_table_root_q;
  logic [31:0] window_q [4];
  logic [31:0] prdata_q;
  logic        pslverr_q;
  mtc_pkg::mtc_state_t state_q;
  mtc_pkg::mtc_req_t   search_q;

  // cache arrays: index [unit][set][way]
  logic        tag_valid_q [2][NS][NW];
  logic [18:0] tag_q       [2][NS][NW];
  logic [19:0] frame_q     [2][NS][NW];
  logic        wp_q        [2][NS][NW];
  logic [1:0]  cm_q        [2][NS][NW];
  logic [1:0]  ua_q        [2][NS][NW];
  logic [1:0]  victim_q    [2][NS];

  wire setup     = psel_in & ~penable_in;
  wire access    = psel_in & penable_in;
  wire wr_ok     = access & pwrite_in & pprot_priv_in;
  wire page8     = control_q[mtc_pkg::CTL_PAGE_BIT];
  wire paging_on = control_q[mtc_pkg::CTL_ENABLE_BIT] & ~translation_disable_in;

  // apb: zero wait states
  assign pready_out  = 1'b1;
  assign prdata_out  = prdata_q;
  assign pslverr_out = pslverr_q;

  logic [31:0] rd_value;
  logic        rd_known;
  always_comb begin
    rd_known = 1'b1;
    if (paddr_in == mtc_pkg::OFF_CONTROL) begin
      rd_value = {16'h0000, control_q};
    end else if (paddr_in == mtc_pkg::OFF_USER_ROOT) begin
      rd_value = user_table_root_q;
    end else if (paddr_in == mtc_pkg::OFF_SUPV_ROOT) begin
      rd_value = supervisor_table_root_q;
    end else if (paddr_in == mtc_pkg::OFF_DWIN0) begin
      rd_value = window_q[0];
    end else if (paddr_in == mtc_pkg::OFF_DWIN1) begin
      rd_value = window_q[1];
    end else if (paddr_in == mtc_pkg::OFF_IWIN0) begin
      rd_value = window_q[2];
    end else if (paddr_in == mtc_pkg::OFF_IWIN1) begin
      rd_value = window_q[3];
    end else if (paddr_in == mtc_pkg::OFF_FLUSH || paddr_in == mtc_pkg::OFF_FILL) begin
      rd_value = 32'h0000_0000;
    end else if (paddr_in == mtc_pkg::OFF_STATUS) begin
      rd_value = {29'h0000_0000, search_q.instruction, search_q.supervisor, search_req_out};
    end else begin
      rd_value = 32'h0000_0000;
      rd_known = 1'b0;
    end
  end

  // read data and error captured in the setup cycle, shown in the access cycle
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= (pprot_priv_in && !pwrite_in) ? rd_value : 32'h0000_0000;
      pslverr_q <= ~pprot_priv_in | ~rd_known;
    end
  end

  // enable bit cleared by reset; page bit keeps its value across reset
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enable_q <= 1'b0;
    end else if (wr_ok && paddr_in == mtc_pkg::OFF_CONTROL) begin
      enable_q <= pwdata_in[mtc_pkg::CTL_ENABLE_BIT];
    end
  end
  // no reset here: the page size survives reset
  always_ff @(posedge clock_in) begin
    if (wr_ok && paddr_in == mtc_pkg::OFF_CONTROL) begin
      page_q <= pwdata_in[mtc_pkg::CTL_PAGE_BIT];
    end
  end
  // unimplemented bits are constant zero
  assign control_q = {enable_q, page_q, 14'h0000};

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      user_table_root_q       <= 32'h0000_0000;
      supervisor_table_root_q <= 32'h0000_0000;
    end else if (wr_ok && paddr_in == mtc_pkg::OFF_USER_ROOT) begin
      user_table_root_q <= pwdata_in;
    end else if (wr_ok && paddr_in == mtc_pkg::OFF_SUPV_ROOT) begin
      supervisor_table_root_q <= pwdata_in;
    end
  end

  // windows 0,1 data; 2,3 instruction
  logic [3:0] win_hit;
  genvar gw;
  generate
    for (gw = 0; gw < 4; gw++) begin : g_win
      localparam logic [7:0] WOFF = mtc_pkg::OFF_DWIN0 + 8'(4 * gw);
      always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          window_q[gw] <= 32'h0000_0000;
        end else if (wr_ok && paddr_in == WOFF) begin
          window_q[gw] <= pwdata_in & mtc_pkg::WIN_WRITE_MASK;
        end
      end
      wire [7:0] base = window_q[gw][31:24];
      wire [7:0] mask = window_q[gw][23:16];
      wire       addr_ok = ((base ^ req_in.address[31:24]) & ~mask) == 8'h00;
      wire       priv_ok = window_q[gw][mtc_pkg::WIN_PRIV_HI] |
                           (window_q[gw][mtc_pkg::WIN_PRIV_LO] == req_in.supervisor);
      wire       side_ok = (gw >= 2) == req_in.instruction;
      // independent of enable bit and disable input
      assign win_hit[gw] = window_q[gw][mtc_pkg::WIN_ENABLE_BIT] & addr_ok & priv_ok & side_ok;
    end
  endgenerate

  logic [1:0] win_sel;
  always_comb begin
    win_sel = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (win_hit[i]) begin
        win_sel = 2'(i);
      end
    end
  end
  wire [31:0] win_word = window_q[win_sel];

  // cache lookup, combinational so the answer lands with the cache index
  wire         unit   = req_in.instruction;
  wire [SB-1:0] set_i = page8 ? req_in.address[13+SB-1:13] : req_in.address[12+SB-1:12];
  // tag: privilege, then the address bits above the set index
  wire [18:0]  tag_i  = {req_in.supervisor, 2'b00,
                         page8 ? {1'b0, req_in.address[31:17]} : req_in.address[31:16]};
  logic        hit;
  logic [1:0]  hit_way;
  always_comb begin
    hit     = 1'b0;
    hit_way = 2'h0;
    for (int w = 0; w < NW; w++) begin
      if (tag_valid_q[unit][set_i][w] && tag_q[unit][set_i][w] == tag_i) begin
        hit     = 1'b1;
        hit_way = 2'(w);
      end
    end
  end

  // answer to the integer unit
  always_comb begin
    rsp_out = '0;
    rsp_out.address    = req_in.address;
    rsp_out.cache_mode = mtc_pkg::CM_WRITE_THROUGH;
    if (req_in.valid) begin
      if (|win_hit) begin
        rsp_out.hit         = 1'b1;
        rsp_out.transparent = 1'b1;
        rsp_out.cache_mode  = win_word[mtc_pkg::WIN_CM_HI:mtc_pkg::WIN_CM_LO];
        rsp_out.abort       = req_in.write & win_word[mtc_pkg::WIN_WP_BIT];
        rsp_out.user_attribute_pin_high = bus_request_in & win_word[mtc_pkg::WIN_UHI_BIT];
        rsp_out.user_attribute_pin_low  = bus_request_in & win_word[mtc_pkg::WIN_ULO_BIT];
      end else if (!paging_on) begin
        rsp_out.hit = 1'b1;
      end else if (hit) begin
        rsp_out.hit        = 1'b1;
        rsp_out.address    = {frame_q[unit][set_i][hit_way][19:1],
                              page8 ? req_in.address[12] : frame_q[unit][set_i][hit_way][0],
                              req_in.address[11:0]};
        rsp_out.cache_mode = cm_q[unit][set_i][hit_way];
        rsp_out.abort      = req_in.write & wp_q[unit][set_i][hit_way];
        rsp_out.user_attribute_pin_high = bus_request_in & ua_q[unit][set_i][hit_way][1];
        rsp_out.user_attribute_pin_low  = bus_request_in & ua_q[unit][set_i][hit_way][0];
      end else begin
        rsp_out.miss = 1'b1;
      end
    end
  end
  assign bus_start_out = bus_request_in & rsp_out.hit & ~rsp_out.abort;

  // table search handshake: fill word is {frame[31:12], ua[1:0], cm[1:0], wp, ...}
  wire fill_wr  = wr_ok && paddr_in == mtc_pkg::OFF_FILL;
  wire flush_wr = wr_ok && paddr_in == mtc_pkg::OFF_FLUSH;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q  <= mtc_pkg::ST_IDLE;
      search_q <= '0;
    end else begin
      case (state_q)
        mtc_pkg::ST_IDLE: begin
          if (rsp_out.miss) begin
            search_q <= req_in;
            state_q  <= mtc_pkg::ST_SEARCH;
          end
        end
        mtc_pkg::ST_SEARCH: begin
          state_q <= mtc_pkg::ST_WAIT_FILL;
        end
        mtc_pkg::ST_WAIT_FILL: begin
          if (fill_wr || flush_wr) begin
            state_q <= mtc_pkg::ST_IDLE;
          end
        end
        default: state_q <= mtc_pkg::ST_IDLE;
      endcase
    end
  end
  assign search_req_out  = state_q != mtc_pkg::ST_IDLE;
  assign search_addr_out = search_q.address;
  assign search_root_out = search_q.supervisor ? supervisor_table_root_q : user_table_root_q;
  assign search_inst_out = search_q.instruction;

  // per-unit caches; flush ignores the enable bit and reset leaves contents alone
  wire          f_unit = search_q.instruction;
  wire [SB-1:0] f_set  = page8 ? search_q.address[13+SB-1:13] : search_q.address[12+SB-1:12];
  wire [18:0]   f_tag  = {search_q.supervisor, 2'b00,
                          page8 ? {1'b0, search_q.address[31:17]} : search_q.address[31:16]};
  genvar gu, gs, gv;
  generate
    for (gu = 0; gu < 2; gu++) begin : g_unit
      for (gs = 0; gs < NS; gs++) begin : g_set
        wire fill_here = fill_wr && state_q == mtc_pkg::ST_WAIT_FILL && f_unit == gu && f_set == gs;
        // the pointer needs a known start or no fill would ever land
        always_ff @(posedge clock_in or negedge reset_n_in) begin
          if (!reset_n_in) begin
            victim_q[gu][gs] <= 2'h0;
          end else if (fill_here) begin
            victim_q[gu][gs] <= victim_q[gu][gs] + 2'h1;
          end
        end
        for (gv = 0; gv < NW; gv++) begin : g_way
          always_ff @(posedge clock_in) begin
            if (fill_here && victim_q[gu][gs] == gv) begin
              tag_valid_q[gu][gs][gv] <= 1'b1;
              tag_q[gu][gs][gv]       <= f_tag;
              frame_q[gu][gs][gv]     <= pwdata_in[31:12];
              ua_q[gu][gs][gv]        <= pwdata_in[9:8];
              cm_q[gu][gs][gv]        <= pwdata_in[6:5];
              wp_q[gu][gs][gv]        <= pwdata_in[2];
            end else if (flush_wr) begin
              tag_valid_q[gu][gs][gv] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate
endmodule : mtc_top
`default_nettype wire

/* testbench/mtc_partner.sv */
// stand-in for the integer unit and cache controller
// assumes bench commands change by nonblocking assignment at the rising edge
`timescale 1ns/1ps
`default_nettype none
module mtc_partner (
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              reset_n_in,
  // bench commands
  input  wire mtc_pkg::mtc_req_t cmd_in,
  input  wire logic              want_bus_in,
  // towards the block
  output var  mtc_pkg::mtc_req_t req_out,
  output var  logic              bus_request_out
);
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_out <= '0;
      bus_request_out <= 1'b0;
    end else begin
      req_out <= cmd_in;
      // an idle address keeps toggling so nothing stale looks valid
      if (!cmd_in.valid) begin
        req_out.address <= ~req_out.address;
      end
      bus_request_out <= want_bus_in;
    end
  end
endmodule : mtc_partner
`default_nettype wire

/* testbench/mtc_top_properties.sv */
// port checker for the translation control block
// assumes binding onto mtc_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module mtc_top_properties (
  input wire logic              clock_in,
  input wire logic              reset_n_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pprot_priv_in,
  input wire logic              pslverr_out,
  input wire logic [31:0]       prdata_out,
  input wire mtc_pkg::mtc_req_t req_in,
  input wire mtc_pkg::mtc_rsp_t rsp_out,
  input wire logic              bus_request_in,
  input wire logic              bus_start_out,
  input wire logic              translation_disable_in,
  input wire logic              search_req_out,
  input wire logic [31:0]       search_addr_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  wire logic       v    = req_in.valid;
  wire logic [1:0] pins = {rsp_out.user_attribute_pin_high, rsp_out.user_attribute_pin_low};

  property p_fast;
    v && rsp_out.hit && !rsp_out.abort && bus_request_in |-> bus_start_out;
  endproperty
  a_fast: assert property (p_fast) else $error("resident hit gave no bus start");
  property p_bus;
    bus_start_out |-> bus_request_in && rsp_out.hit && !rsp_out.abort;
  endproperty
  a_bus: assert property (p_bus) else $error("bus start without request");
  property p_dis;
    v && translation_disable_in |-> !rsp_out.miss && rsp_out.address == req_in.address;
  endproperty
  a_dis: assert property (p_dis) else $error("disable input did not stop paging");
  property p_dflt;
    v && translation_disable_in && !rsp_out.transparent |-> rsp_out.cache_mode == 2'h0 && !rsp_out.abort;
  endproperty
  a_dflt: assert property (p_dflt) else $error("default attributes wrong");
  property p_pins;
    !bus_request_in |-> pins == 2'h0;
  endproperty
  a_pins: assert property (p_pins) else $error("attribute pins without bus transfer");
  property p_win;
    v && rsp_out.transparent |-> rsp_out.address == req_in.address && !rsp_out.miss;
  endproperty
  a_win: assert property (p_win) else $error("window hit changed the address");
  property p_miss;
    v && rsp_out.miss |=> search_req_out && search_addr_out == $past(req_in.address);
  endproperty
  a_miss: assert property (p_miss) else $error("miss raised no table search");
  property p_priv;
    psel_in && penable_in && !pprot_priv_in |-> pslverr_out && prdata_out == 32'h0;
  endproperty
  a_priv: assert property (p_priv) else $error("user access was not refused");
  c_miss: cover property (v && rsp_out.miss);
  c_win: cover property (v && rsp_out.transparent);
  c_start: cover property (bus_start_out);
  c_err: cover property (psel_in && penable_in && pslverr_out);
endmodule : mtc_top_properties

bind mtc_top mtc_top_properties u_props (.clock_in, .reset_n_in, .psel_in, .penable_in, .pprot_priv_in,
  .pslverr_out, .prdata_out, .req_in, .rsp_out, .bus_request_in, .bus_start_out, .translation_disable_in,
  .search_req_out, .search_addr_out);
`default_nettype wire

/* testbench/mtc_top_tb_top.sv */
// self-checking bench for the translation control block
// assumes the partner model stands in for integer unit and cache controller
`timescale 1ns/1ps
`default_nettype none
module mtc_top_tb_top;
  logic              clock_in, reset_n_in, psel_in, penable_in, pwrite_in, pprot_priv_in, want, bs, err;
  logic              translation_disable_in, pready_out, pslverr_out, bus_request_in, bus_start_out;
  logic              search_req_out, search_inst_out;
  logic [7:0]        paddr_in;
  logic [31:0]       pwdata_in, prdata_out, search_addr_out, search_root_out, rd;
  mtc_pkg::mtc_req_t cmd, req_in;
  mtc_pkg::mtc_rsp_t rsp_out, r;
  int                errors, compares;

  mtc_partner u_partner (.clock_in, .reset_n_in, .cmd_in(cmd), .want_bus_in(want), .req_out(req_in),
    .bus_request_out(bus_request_in));
  mtc_top dut (.clock_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pprot_priv_in,
    .pready_out, .prdata_out, .pslverr_out, .req_in, .rsp_out, .bus_request_in, .bus_start_out,
    .translation_disable_in, .search_req_out, .search_addr_out, .search_root_out, .search_inst_out);

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkb

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do @(posedge clock_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // one data lookup, answer sampled once the partner has presented it
  task automatic look(input logic [31:0] a, input logic s, input logic w, input logic b);
    @(posedge clock_in);
    cmd <= '{1'b1, s, w, 1'b0, a};
    want <= b;
    repeat (2) @(posedge clock_in);
    r = rsp_out;
    bs = bus_start_out;
    cmd.valid <= 1'b0;
    want <= 1'b0;
  endtask : look

  task automatic t_regs();
    apb(1'b0, mtc_pkg::OFF_CONTROL, 32'h0);
    chk(rd & 32'hFFFFBFFF, 32'h0);
    rdc(mtc_pkg::OFF_DWIN0, 32'h0);
    wr(mtc_pkg::OFF_CONTROL, 32'hFFFFFFFF);
    rdc(mtc_pkg::OFF_CONTROL, 32'h0000C000);
    wr(mtc_pkg::OFF_IWIN1, 32'hFFFFFFFF);
    rdc(mtc_pkg::OFF_IWIN1, 32'hFFFFE364);
    wr(mtc_pkg::OFF_USER_ROOT, 32'h13572468);
    pprot_priv_in <= 1'b0;
    wr(mtc_pkg::OFF_USER_ROOT, 32'h0);
    chkb(err, 1'b1);
    pprot_priv_in <= 1'b1;
    rdc(mtc_pkg::OFF_USER_ROOT, 32'h13572468);
    apb(1'b0, 8'h3C, 32'h0);
    chkb(err, 1'b1);
    wr(mtc_pkg::OFF_IWIN1, 32'h0);
    wr(mtc_pkg::OFF_CONTROL, 32'h0);
    wr(mtc_pkg::OFF_FLUSH, 32'h0);
    chkb(err, 1'b0);
    look(32'h12345678, 1'b1, 1'b1, 1'b1);
    chk(r.address, 32'h12345678);
    chk({26'h0, r.cache_mode, r.miss, r.abort, r.user_attribute_pin_high, r.user_attribute_pin_low}, 32'h0);
  endtask : t_regs

  task automatic t_win();
    logic m;
    for (int i = 0; i < 8; i++) begin
      wr(mtc_pkg::OFF_DWIN0, {16'h4001, 1'b1, i[1:0], 5'h02, 1'b0, i[1:0], 5'h00});
      look(32'h410000F0, i[2], 1'b0, 1'b1);
      m = i[1] | (i[0] == i[2]);
      chkb(r.transparent, m);
      if (m) begin
        chk({30'h0, r.cache_mode}, {30'h0, i[1:0]});
        chk({30'h0, r.user_attribute_pin_high, r.user_attribute_pin_low}, 32'h2);
        chk(r.address, 32'h410000F0);
      end
    end
    wr(mtc_pkg::OFF_DWIN0, 32'h40004000);
    look(32'h400000F0, 1'b0, 1'b0, 1'b1);
    chkb(r.transparent, 1'b0);
    wr(mtc_pkg::OFF_DWIN0, 32'h4000C004);
    look(32'h410000F0, 1'b0, 1'b0, 1'b1);
    chkb(r.transparent, 1'b0);
    look(32'h400000F0, 1'b0, 1'b1, 1'b0);
    chk({29'h0, r.transparent, r.abort, r.user_attribute_pin_low}, 32'h6);
    wr(mtc_pkg::OFF_DWIN0, 32'h0);
  endtask : t_win

  task automatic t_page();
    wr(mtc_pkg::OFF_FLUSH, 32'h0);
    wr(mtc_pkg::OFF_SUPV_ROOT, 32'h0000A000);
    wr(mtc_pkg::OFF_CONTROL, 32'h00008000);
    look(32'h12345678, 1'b1, 1'b0, 1'b1);
    chk({30'h0, r.miss, bs}, 32'h2);
    @(posedge clock_in);
    chkb(search_req_out, 1'b1);
    chk(search_addr_out, 32'h12345678);
    chk(search_root_out, 32'h0000A000);
    chkb(search_inst_out, 1'b0);
    wr(mtc_pkg::OFF_FILL, 32'hABCDE020);
    wr(mtc_pkg::OFF_CONTROL, 32'h00008000);
    look(32'h12345678, 1'b1, 1'b0, 1'b1);
    chk(r.address, 32'hABCDE678);
    chk({29'h0, r.cache_mode, search_req_out}, 32'h2);
    chkb(bs, 1'b1);
    look(32'h12345678, 1'b1, 1'b0, 1'b0);
    chkb(bs, 1'b0);
    translation_disable_in <= 1'b1;
    look(32'h12345678, 1'b1, 1'b0, 1'b1);
    chk(r.address, 32'h12345678);
    translation_disable_in <= 1'b0;
    wr(mtc_pkg::OFF_DWIN1, 32'h1200C000);
    look(32'h12345678, 1'b0, 1'b0, 1'b1);
    chkb(r.transparent, 1'b1);
    wr(mtc_pkg::OFF_DWIN1, 32'h0);
    wr(mtc_pkg::OFF_FLUSH, 32'h0);
    look(32'h12345678, 1'b1, 1'b0, 1'b1);
    chkb(r.miss, 1'b1);
    wr(mtc_pkg::OFF_FLUSH, 32'h0);
    @(posedge clock_in);
    chkb(search_req_out, 1'b0);
    wr(mtc_pkg::OFF_CONTROL, 32'h0);
  endtask : t_page

  task automatic finish_test();
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  initial begin
    errors = 0;
    compares = 0;
    reset_n_in = 1'b0;
    {psel_in, penable_in, pwrite_in, translation_disable_in, want} = 5'h00;
    pprot_priv_in = 1'b1;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    cmd = '0;
    repeat (4) @(posedge clock_in);
    reset_n_in <= 1'b1;
    t_regs();
    t_win();
    t_page();
    finish_test();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock_in);
    errors++;
    finish_test();
  end
endmodule : mtc_top_tb_top
`default_nettype wire
